/* File: pkg/dcrs_pkg.sv */
package dcrs_pkg;
    // widths of the register path and of time values
    localparam int             DCRS_ADDR_W        = 12;
    localparam int             DCRS_DATA_W        = 32;
    localparam int             DCRS_TIME_W        = 64;

    // register word offsets
    localparam logic [11:0]    DCRS_OFF_LATCH_TRIG = 12'h900;
    localparam logic [11:0]    DCRS_OFF_P1_STAMP   = 12'h904;
    localparam logic [11:0]    DCRS_OFF_P2_STAMP   = 12'h908;
    localparam logic [11:0]    DCRS_OFF_SYS_LO     = 12'h910;
    localparam logic [11:0]    DCRS_OFF_SYS_HI     = 12'h914;
    localparam logic [11:0]    DCRS_OFF_PU_LO      = 12'h918;
    localparam logic [11:0]    DCRS_OFF_PU_HI      = 12'h91c;
    localparam logic [11:0]    DCRS_OFF_OFS_LO     = 12'h920;
    localparam logic [11:0]    DCRS_OFF_OFS_HI     = 12'h924;

    // reset values
    localparam logic [63:0]    DCRS_SYS_TIME_RST   = 64'h0;
    localparam logic [63:0]    DCRS_OFFSET_RST     = 64'h0;
    localparam logic [63:0]    DCRS_STAMP_RST      = 64'h0;
    localparam logic [31:0]    DCRS_WORD_ZERO      = 32'h0;

    // local time advances by one clock period in ns per cycle
    localparam int             DCRS_CLK_PERIOD_NS  = 4;
    localparam logic [63:0]    DCRS_TIME_STEP      = 64'(DCRS_CLK_PERIOD_NS);

    // preamble ingress indices
    localparam int             DCRS_NUM_INGRESS    = 4;
    localparam int             DCRS_IDX_P0         = 0;
    localparam int             DCRS_IDX_P1         = 1;
    localparam int             DCRS_IDX_P2         = 2;
    localparam int             DCRS_IDX_PU         = 3;
endpackage : dcrs_pkg

/* File: rtl/dcrs_time_compare.sv */
`timescale 1ns/10ps
module dcrs_time_compare
    import dcrs_pkg::*;
(
    input  wire logic [dcrs_pkg::DCRS_DATA_W-1:0] received,  // written system time
    input  wire logic [dcrs_pkg::DCRS_DATA_W-1:0] local_copy, // local system time copy
    output logic      [dcrs_pkg::DCRS_DATA_W-1:0] diff,      // received minus local
    output logic                                  local_ge   // local copy not below received
);
    logic [DCRS_DATA_W-1:0] local_minus_rx;

    // modulo difference both ways; sign of local minus received gives the order
    always_comb begin
        diff           = received - local_copy;
        local_minus_rx = local_copy - received;
        local_ge       = ~local_minus_rx[DCRS_DATA_W-1];
    end
endmodule : dcrs_time_compare

/* File: rtl/dcrs_dc_time.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - port 1 latch-trigger write stamps preamble time
// - port 2 latch-trigger write stamps preamble time
// - network read returns frame-start system time
// - host low-word read snapshots whole system time
// - network low-word write compares at frame end, host write compares at once
// - configuration picks network or host writer
// - any valid latch-trigger write latches processing-unit stamp while port 0 is closed
// - port 0 open: unit stamp mirrors port 0
// - system time equals local time plus offset
// - registers accessed as 32-bit words
// - system time and offset reset to zero
// - only broadcast/configured writes latch port stamps
// - stamps update only after the frame ends
module dcrs_dc_time
    import dcrs_pkg::*;
(
    input  wire logic                                  CLK,              // 250 MHz clock
    input  wire logic                                  RST_N,            // async reset, active low
    input  wire logic                                  CE,               // clock enable
    input  wire logic [dcrs_pkg::DCRS_NUM_INGRESS-1:0] FRM_PREAMBLE,     // first preamble bit per ingress
    input  wire logic                                  FRM_SOF,          // start-of-frame delimiter pulse
    input  wire logic                                  FRM_END,          // end of frame pulse
    input  wire logic                                  FRM_VALID,        // frame good, with FRM_END
    input  wire logic                                  NET_WR,           // network-side word write
    input  wire logic                                  NET_RD,           // network-side word read
    input  wire logic [dcrs_pkg::DCRS_ADDR_W-1:0]      NET_ADDR,         // network-side word address
    input  wire logic [dcrs_pkg::DCRS_DATA_W-1:0]      NET_WDATA,        // network-side write data
    input  wire logic                                  NET_LATCH_CMD,    // write is broadcast or configured
    input  wire logic                                  HOST_WR,          // host-side word write
    input  wire logic                                  HOST_RD,          // host-side word read
    input  wire logic [dcrs_pkg::DCRS_ADDR_W-1:0]      HOST_ADDR,        // host-side word address
    input  wire logic [dcrs_pkg::DCRS_DATA_W-1:0]      HOST_WDATA,       // host-side write data
    input  wire logic                                  PORT0_OPEN,       // port 0 open
    input  wire logic                                  HOST_SYS_CTRL,    // host controls system time
    input  wire logic [dcrs_pkg::DCRS_DATA_W-1:0]      SYS_TIME_DELAY,   // delay to reference clock
    output logic      [dcrs_pkg::DCRS_DATA_W-1:0]      NET_RDATA,        // network read data
    output logic                                       NET_RVALID,       // network read data valid
    output logic      [dcrs_pkg::DCRS_DATA_W-1:0]      HOST_RDATA,       // host read data
    output logic                                       HOST_RVALID,      // host read data valid
    output logic      [dcrs_pkg::DCRS_TIME_W-1:0]      SYS_TIME,         // current system time
    output logic                                       CMP_STROBE,       // comparison result pulse
    output logic                                       CMP_GE,           // local copy >= received
    output logic      [dcrs_pkg::DCRS_DATA_W-1:0]      CMP_DIFF          // received minus local copy
);
    typedef struct packed {
        logic [63:0]                       local_time;
        logic [63:0]                       offset;
        logic [63:0]                       sys_time;
        logic [DCRS_NUM_INGRESS-1:0][63:0] pend;
        logic [31:0]                       p1_stamp;
        logic [31:0]                       p2_stamp;
        logic [63:0]                       pu_stamp;
        logic [63:0]                       sof_sys;
        logic [31:0]                       host_snap_hi;
        logic [31:0]                       cmp_val;
        logic                              cmp_pend;
        logic                              trig_bc;
        logic                              trig_any;
        logic [31:0]                       net_rdata;
        logic                              net_rvalid;
        logic [31:0]                       host_rdata;
        logic                              host_rvalid;
        logic                              cmp_stb;
        logic                              cmp_ge;
        logic [31:0]                       cmp_diff;
    } dcrs_state_type;

    dcrs_state_type st;
    dcrs_state_type next_st;

    logic [63:0] sys_now;
    logic [63:0] sof_now;
    logic [31:0] cmp_rx;
    logic [31:0] cmp_loc;
    logic [31:0] cmp_diff_w;
    logic        cmp_ge_w;
    logic        net_trig_hit;
    logic        net_sys_wr;
    logic        host_sys_wr;
    logic        frame_ok;

    // word address match
    function automatic logic word_hit(input logic [DCRS_ADDR_W-1:0] addr, input logic [DCRS_ADDR_W-1:0] off);
        word_hit = (addr == off);
    endfunction : word_hit

    // read value of the registers both sides see alike
    function automatic logic [31:0] common_read(input logic [DCRS_ADDR_W-1:0] addr, input dcrs_state_type s);
        common_read = DCRS_WORD_ZERO;
        if (word_hit(addr, DCRS_OFF_P1_STAMP)) common_read = s.p1_stamp;
        if (word_hit(addr, DCRS_OFF_P2_STAMP)) common_read = s.p2_stamp;
        if (word_hit(addr, DCRS_OFF_PU_LO))    common_read = s.pu_stamp[31:0];
        if (word_hit(addr, DCRS_OFF_PU_HI))    common_read = s.pu_stamp[63:32];
        if (word_hit(addr, DCRS_OFF_OFS_LO))   common_read = s.offset[31:0];
        if (word_hit(addr, DCRS_OFF_OFS_HI))   common_read = s.offset[63:32];
    endfunction : common_read

    // live system time and its frame-start view including the path delay
    always_comb begin
        sys_now      = st.local_time + st.offset;
        sof_now      = sys_now + {DCRS_WORD_ZERO, SYS_TIME_DELAY};
        net_trig_hit = NET_WR && word_hit(NET_ADDR, DCRS_OFF_LATCH_TRIG);
        net_sys_wr   = NET_WR && !HOST_SYS_CTRL && word_hit(NET_ADDR, DCRS_OFF_SYS_LO);
        host_sys_wr  = HOST_WR && HOST_SYS_CTRL && word_hit(HOST_ADDR, DCRS_OFF_SYS_LO);
        frame_ok     = FRM_END && FRM_VALID;
    end

    // host compare runs at once against live time, network compare at frame end
    always_comb begin
        if (host_sys_wr) begin
            cmp_rx  = HOST_WDATA;
            cmp_loc = sys_now[31:0];
        end else begin
            cmp_rx  = net_sys_wr ? NET_WDATA : st.cmp_val;                 // a write in the end cycle counts
            cmp_loc = st.sof_sys[31:0];
        end
    end

    dcrs_time_compare u_cmp (
        .received   (cmp_rx),
        .local_copy (cmp_loc),
        .diff       (cmp_diff_w),
        .local_ge   (cmp_ge_w)
    );

    // next state
    always_comb begin
        next_st             = st;
        next_st.cmp_stb     = 1'b0;
        next_st.net_rvalid  = 1'b0;
        next_st.host_rvalid = 1'b0;
        next_st.local_time  = st.local_time + DCRS_TIME_STEP;
        next_st.sys_time    = sys_now;

        // preamble time per ingress, held until the frame ends
        for (int i = 0; i < DCRS_NUM_INGRESS; i++) begin
            if (FRM_PREAMBLE[i]) begin
                next_st.pend[i] = st.local_time;
            end
        end
        if (FRM_SOF) begin
            next_st.sof_sys = sof_now;
        end

        // trigger flags; a write in the end cycle still counts
        if (net_trig_hit) begin
            next_st.trig_any = 1'b1;
            if (NET_LATCH_CMD) begin
                next_st.trig_bc = 1'b1;
            end
        end
        if (net_sys_wr) begin
            next_st.cmp_val  = NET_WDATA;
            next_st.cmp_pend = 1'b1;
        end

        // stamps change only at frame end, so the same frame never sees them
        if (FRM_END) begin
            next_st.trig_any = 1'b0;
            next_st.trig_bc  = 1'b0;
            next_st.cmp_pend = 1'b0;
            if (frame_ok && (st.trig_bc || (net_trig_hit && NET_LATCH_CMD))) begin
                next_st.p1_stamp = st.pend[DCRS_IDX_P1][31:0];
                next_st.p2_stamp = st.pend[DCRS_IDX_P2][31:0];
                if (PORT0_OPEN) begin
                    next_st.pu_stamp = {DCRS_WORD_ZERO, st.pend[DCRS_IDX_P0][31:0]};
                end
            end
            if (frame_ok && !PORT0_OPEN && (st.trig_any || net_trig_hit)) begin
                next_st.pu_stamp = st.pend[DCRS_IDX_PU];
            end
            if (frame_ok && (st.cmp_pend || net_sys_wr) && !host_sys_wr) begin
                next_st.cmp_stb  = 1'b1;
                next_st.cmp_ge   = cmp_ge_w;
                next_st.cmp_diff = cmp_diff_w;
            end
        end
        if (host_sys_wr) begin
            next_st.cmp_stb  = 1'b1;
            next_st.cmp_ge   = cmp_ge_w;
            next_st.cmp_diff = cmp_diff_w;
        end

        // offset written by either side, network wins a clash on one word
        if (HOST_WR && word_hit(HOST_ADDR, DCRS_OFF_OFS_LO)) next_st.offset[31:0]  = HOST_WDATA;
        if (HOST_WR && word_hit(HOST_ADDR, DCRS_OFF_OFS_HI)) next_st.offset[63:32] = HOST_WDATA;
        if (NET_WR && word_hit(NET_ADDR, DCRS_OFF_OFS_LO))   next_st.offset[31:0]  = NET_WDATA;
        if (NET_WR && word_hit(NET_ADDR, DCRS_OFF_OFS_HI))   next_st.offset[63:32] = NET_WDATA;

        // network reads: system time from the frame-start copy
        if (NET_RD) begin
            next_st.net_rvalid = 1'b1;
            next_st.net_rdata  = common_read(NET_ADDR, st);
            if (word_hit(NET_ADDR, DCRS_OFF_SYS_LO)) next_st.net_rdata = st.sof_sys[31:0];
            if (word_hit(NET_ADDR, DCRS_OFF_SYS_HI)) next_st.net_rdata = st.sof_sys[63:32];
        end

        // host reads: low word takes the snapshot, high word returns it
        if (HOST_RD) begin
            next_st.host_rvalid = 1'b1;
            next_st.host_rdata  = common_read(HOST_ADDR, st);
            if (word_hit(HOST_ADDR, DCRS_OFF_SYS_LO)) begin
                next_st.host_rdata   = sys_now[31:0];
                next_st.host_snap_hi = sys_now[63:32];
            end
            if (word_hit(HOST_ADDR, DCRS_OFF_SYS_HI)) next_st.host_rdata = st.host_snap_hi;
        end
    end

    // state register, frozen while CE is low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st              <= '0;
            st.local_time   <= DCRS_SYS_TIME_RST;
            st.offset       <= DCRS_OFFSET_RST;
            st.sys_time     <= DCRS_SYS_TIME_RST;
            st.pu_stamp     <= DCRS_STAMP_RST;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign NET_RDATA   = st.net_rdata;
    assign NET_RVALID  = st.net_rvalid;
    assign HOST_RDATA  = st.host_rdata;
    assign HOST_RVALID = st.host_rvalid;
    assign SYS_TIME    = st.sys_time;
    assign CMP_STROBE  = st.cmp_stb;
    assign CMP_GE      = st.cmp_ge;
    assign CMP_DIFF    = st.cmp_diff;

    // checks on the behaviour above
    sequence s_bc_latch_end;
        CE && frame_ok && st.trig_bc;
    endsequence

    property p_p1_latch;
        @(posedge CLK) disable iff (!RST_N) s_bc_latch_end |=> st.p1_stamp == $past(st.pend[DCRS_IDX_P1][31:0]);
    endproperty
    a_p1_latch: assert property (p_p1_latch) else $error("port 1 stamp not latched");

    property p_p2_latch;
        @(posedge CLK) disable iff (!RST_N) s_bc_latch_end |=> st.p2_stamp == $past(st.pend[DCRS_IDX_P2][31:0]);
    endproperty
    a_p2_latch: assert property (p_p2_latch) else $error("port 2 stamp not latched");

    property p_net_sys_read;
        @(posedge CLK) disable iff (!RST_N)
            CE && NET_RD && word_hit(NET_ADDR, DCRS_OFF_SYS_LO) |=> NET_RVALID && NET_RDATA == $past(st.sof_sys[31:0]);
    endproperty
    a_net_sys_read: assert property (p_net_sys_read) else $error("network system time read wrong");

    property p_host_snapshot;
        @(posedge CLK) disable iff (!RST_N)
            CE && HOST_RD && word_hit(HOST_ADDR, DCRS_OFF_SYS_LO) |=> st.host_snap_hi == $past(sys_now[63:32]);
    endproperty
    a_host_snapshot: assert property (p_host_snapshot) else $error("host snapshot wrong");

    sequence s_net_cmp_end;
        CE && frame_ok && (st.cmp_pend || net_sys_wr) && !host_sys_wr;
    endsequence

    property p_cmp_end;
        @(posedge CLK) disable iff (!RST_N)
            s_net_cmp_end |=> CMP_STROBE && CMP_DIFF == $past((net_sys_wr ? NET_WDATA : st.cmp_val) - st.sof_sys[31:0]);
    endproperty
    a_cmp_end: assert property (p_cmp_end) else $error("frame end compare missing");

    property p_write_select;
        @(posedge CLK) disable iff (!RST_N)
            CE && HOST_WR && !HOST_SYS_CTRL && !NET_WR |=> $stable(st.cmp_val);
    endproperty
    a_write_select: assert property (p_write_select) else $error("host wrote system time while not owner");

    property p_pu_port0;
        @(posedge CLK) disable iff (!RST_N)
            s_bc_latch_end and PORT0_OPEN |=> st.pu_stamp == {32'h0, $past(st.pend[DCRS_IDX_P0][31:0])};
    endproperty
    a_pu_port0: assert property (p_pu_port0) else $error("unit stamp not port 0 mirror");

    property p_sys_sum;
        @(posedge CLK) disable iff (!RST_N) CE |=> SYS_TIME == $past(st.local_time) + $past(st.offset);
    endproperty
    a_sys_sum: assert property (p_sys_sum) else $error("system time not local plus offset");

    property p_stamp_hold;
        @(posedge CLK) disable iff (!RST_N) !FRM_END |=> $stable(st.p1_stamp) && $stable(st.pu_stamp);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold) else $error("stamp changed inside a frame");

    property p_local_step;
        @(posedge CLK) disable iff (!RST_N) CE |=> st.local_time == $past(st.local_time) + DCRS_TIME_STEP;
    endproperty
    a_local_step: assert property (p_local_step) else $error("local time not advancing");
endmodule : dcrs_dc_time

/* File: bench/dcrs_frame_master.sv */
`timescale 1ns/10ps
module dcrs_frame_master (
    input  wire logic        clk,      // bench clock
    input  wire logic        go,       // start one frame
    input  wire logic        cmd,      // write is broadcast or configured
    input  wire logic [11:0] addr,     // word written in the frame
    input  wire logic [31:0] data,     // value written in the frame
    input  wire logic        good,     // frame ends valid
    output logic      [3:0]  preamble, // first preamble bit per ingress
    output logic             sof,      // start-of-frame delimiter
    output logic             fend,     // end of frame
    output logic             fvalid,   // frame good at its end
    output logic             wr,       // network word write
    output logic      [11:0] waddr,    // write address
    output logic      [31:0] wdata,    // write data
    output logic             wcmd,     // write qualifier
    output logic             busy      // frame in flight
);
    logic [4:0] step = 5'h0;

    // frame schedule, one step per clock, idle at zero
    always_ff @(posedge clk) begin
        if (go) begin
            step <= 5'h1;
        end else if (step != 5'h0) begin
            step <= (step == 5'h15) ? 5'h0 : step + 5'h1;
        end
    end

    // port 1 first, port 0 and 2 one cycle later, processing unit last
    assign preamble = {step == 5'h3, step == 5'h2, step == 5'h1, step == 5'h2};
    assign sof      = step == 5'h4;
    assign wr       = step == 5'hb;
    assign fend     = step == 5'h15;
    assign fvalid   = fend & good;
    // released lines show the inverse of the current input value
    assign waddr    = wr ? addr : ~addr;
    assign wdata    = wr ? data : ~data;
    assign wcmd     = wr ? cmd : ~cmd;
    assign busy     = step != 5'h0;
endmodule : dcrs_frame_master

/* File: bench/tb_dc_receive_stamp_system_time.sv */
`timescale 1ns/10ps
module tb_dc_receive_stamp_system_time;
    import dcrs_pkg::*;
    typedef struct packed {logic [1:0] mode; logic [31:0] val;} dcrs_note_type;
    logic clk, rst_n, ce, pm_go, pm_cmd, pm_good, net_rd, host_rd, host_wr, p0_open, host_ctrl;
    logic [11:0] pm_addr, net_raddr, host_addr;
    logic [31:0] pm_data, host_wdata, delay, rnd, h, net_rdata, host_rdata, cmp_diff, pm_wdata;
    logic [3:0] pm_pre;
    logic pm_sof, pm_end, pm_valid, pm_wr, pm_wcmd, pm_busy, net_rvalid, host_rvalid, cmp_strobe, cmp_ge;
    logic [11:0] pm_waddr;
    logic [63:0] sys_time;
    dcrs_note_type note_q[3][$];
    logic [31:0] base[3];
    int err_count = 0, comparisons = 0, cyc = 0, go_cyc, ga, gb;

    dcrs_frame_master dcrs_frame_master_i (.clk(clk), .go(pm_go), .cmd(pm_cmd), .addr(pm_addr), .data(pm_data),
        .good(pm_good), .preamble(pm_pre), .sof(pm_sof), .fend(pm_end), .fvalid(pm_valid), .wr(pm_wr),
        .waddr(pm_waddr), .wdata(pm_wdata), .wcmd(pm_wcmd), .busy(pm_busy));
    dcrs_dc_time dcrs_dc_time_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .FRM_PREAMBLE(pm_pre), .FRM_SOF(pm_sof),
        .FRM_END(pm_end), .FRM_VALID(pm_valid), .NET_WR(pm_wr), .NET_RD(net_rd),
        .NET_ADDR(pm_wr ? pm_waddr : net_raddr), .NET_WDATA(pm_wdata), .NET_LATCH_CMD(pm_wcmd),
        .HOST_WR(host_wr), .HOST_RD(host_rd), .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata),
        .PORT0_OPEN(p0_open), .HOST_SYS_CTRL(host_ctrl), .SYS_TIME_DELAY(delay), .NET_RDATA(net_rdata),
        .NET_RVALID(net_rvalid), .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid), .SYS_TIME(sys_time),
        .CMP_STROBE(cmp_strobe), .CMP_GE(cmp_ge), .CMP_DIFF(cmp_diff));

    // clock and cycle count
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc++;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // mode 0 absolute, 1 keeps a base, 2 compares against the base
    task automatic note(input int ch, input logic [1:0] m, input logic [31:0] v);
        note_q[ch].push_back('{m, v});
    endtask : note

    task automatic judge(input int ch, input logic [31:0] seen, input logic [31:0] flat);
        dcrs_note_type n;
        if (note_q[ch].size() == 0) begin
            n.mode = 2'd0;
            n.val  = ~flat;
        end else begin
            n = note_q[ch].pop_front();
        end
        if (n.mode == 2'd1) begin
            base[ch] = seen;
        end else begin
            check((n.mode == 2'd2) ? seen - base[ch] : flat, n.val);
        end
    endtask : judge

    // results are matched to the oldest note; unexpected results mismatch
    always @(posedge clk) begin
        if (host_rvalid === 1'b1) judge(0, host_rdata, host_rdata);
        if (net_rvalid === 1'b1) judge(1, net_rdata, net_rdata);
        if (cmp_strobe === 1'b1) judge(2, cmp_diff, {31'h0, cmp_ge});
    end

    task automatic hrd(input logic [11:0] a, input logic [1:0] m, input logic [31:0] v);
        @(negedge clk);
        host_rd = 1'b1;
        host_addr = a;
        note(0, m, v);
        @(negedge clk);
        host_rd = 1'b0;
    endtask : hrd

    task automatic nrd(input logic [11:0] a, input logic [1:0] m, input logic [31:0] v);
        @(negedge clk);
        net_rd = 1'b1;
        net_raddr = a;
        note(1, m, v);
        @(negedge clk);
        net_rd = 1'b0;
    endtask : nrd

    task automatic hwr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        host_wr = 1'b0;
    endtask : hwr

    task automatic frame(input logic c, input logic [11:0] a, input logic [31:0] d, input logic g);
        int n;
        @(negedge clk);
        {pm_cmd, pm_addr, pm_data, pm_good, pm_go} = {c, a, d, g, 1'b1};
        go_cyc = cyc;
        @(negedge clk);
        pm_go = 1'b0;
        for (n = 0; n < 40 && pm_busy; n++) @(negedge clk);
        if (pm_busy) begin
            err_count++;
            print_verdict();
        end
    endtask : frame

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        {rst_n, pm_go, pm_cmd, pm_good, net_rd, host_rd, host_wr, p0_open, host_ctrl} = '0;
        {pm_addr, net_raddr, host_addr, pm_data, host_wdata, delay} = '0;
        ce = 1'b1;
        rnd = 32'h84caff10;
        repeat (5) @(posedge clk);
        check(sys_time[63:32] | sys_time[31:0], 32'h0);
        @(negedge clk);
        rst_n = 1'b1;
        hrd(DCRS_OFF_OFS_LO, 2'd0, 32'h0);
        hrd(DCRS_OFF_OFS_HI, 2'd0, 32'h0);
        hrd(12'h930, 2'd0, 32'h0);
        rnd = lfsr(rnd);
        hwr(DCRS_OFF_OFS_HI, rnd);
        hrd(DCRS_OFF_OFS_HI, 2'd0, rnd);
        h = ~rnd;
        frame(1'b1, DCRS_OFF_OFS_HI, h, 1'b1);
        hrd(DCRS_OFF_OFS_HI, 2'd0, h);
        check(sys_time[63:32], h);
        hrd(DCRS_OFF_SYS_LO, 2'd1, 32'h0);
        hrd(DCRS_OFF_SYS_HI, 2'd0, h);
        // latch frame, then a frame that latches only the unit stamp, with a new delay
        frame(1'b1, DCRS_OFF_LATCH_TRIG, 32'h0, 1'b1);
        ga = go_cyc;
        hrd(DCRS_OFF_P1_STAMP, 2'd1, 32'h0);
        hrd(DCRS_OFF_P2_STAMP, 2'd2, 32'h4);
        hrd(DCRS_OFF_PU_LO, 2'd2, 32'h8);
        hrd(DCRS_OFF_PU_HI, 2'd0, 32'h0);
        nrd(DCRS_OFF_SYS_LO, 2'd1, 32'h0);
        nrd(DCRS_OFF_SYS_HI, 2'd0, h);
        hwr(DCRS_OFF_P1_STAMP, 32'hffffffff);
        hrd(DCRS_OFF_P1_STAMP, 2'd2, 32'h0);
        delay = 32'h30;
        frame(1'b0, DCRS_OFF_LATCH_TRIG, 32'h0, 1'b1);
        gb = go_cyc;
        hrd(DCRS_OFF_P1_STAMP, 2'd2, 32'h0);
        hrd(DCRS_OFF_PU_LO, 2'd2, 32'(gb - ga) * DCRS_TIME_STEP[31:0] + 32'h8);
        nrd(DCRS_OFF_SYS_LO, 2'd2, 32'(gb - ga) * DCRS_TIME_STEP[31:0] + 32'h30);
        frame(1'b1, DCRS_OFF_LATCH_TRIG, 32'h0, 1'b0);
        hrd(DCRS_OFF_P1_STAMP, 2'd2, 32'h0);
        p0_open = 1'b1;
        frame(1'b1, DCRS_OFF_LATCH_TRIG, 32'h0, 1'b1);
        hrd(DCRS_OFF_P1_STAMP, 2'd1, 32'h0);
        hrd(DCRS_OFF_PU_LO, 2'd2, 32'h4);
        hrd(DCRS_OFF_PU_HI, 2'd0, 32'h0);
        p0_open = 1'b0;
        // frame-end compares, refused writers, host back-to-back compares
        note(2, 2'd0, 32'h0);
        frame(1'b1, DCRS_OFF_SYS_LO, 32'h70000000, 1'b1);
        note(2, 2'd0, 32'h1);
        frame(1'b1, DCRS_OFF_SYS_LO, 32'h0, 1'b1);
        frame(1'b1, DCRS_OFF_SYS_HI, 32'h0, 1'b1);
        hwr(DCRS_OFF_SYS_LO, 32'h0);
        host_ctrl = 1'b1;
        frame(1'b1, DCRS_OFF_SYS_LO, 32'h0, 1'b1);
        rnd = lfsr(rnd);
        note(2, 2'd1, 32'h0);
        note(2, 2'd2, 32'h100 - DCRS_TIME_STEP[31:0]);
        // two host compares on consecutive edges, strobe held high between them
        @(negedge clk);
        {host_wr, host_addr, host_wdata} = {1'b1, DCRS_OFF_SYS_LO, rnd};
        @(negedge clk);
        host_wdata = rnd + 32'h100;
        @(negedge clk);
        host_wr = 1'b0;
        repeat (4) @(negedge clk);
        // clock enable low freezes system time, one enabled edge steps it again
        ce = 1'b0;
        h = sys_time[31:0];
        repeat (3) @(negedge clk);
        check(sys_time[31:0], h);
        ce = 1'b1;
        @(negedge clk);
        check(sys_time[31:0], h + DCRS_TIME_STEP[31:0]);
        check(32'(note_q[0].size() + note_q[1].size() + note_q[2].size()), 32'h0);
        print_verdict();
    end
endmodule : tb_dc_receive_stamp_system_time
